//--- verilog/cmp_trig_defines.vh
// register offsets, field positions, reset values and codes of the comparator trigger control
`ifndef CMP_TRIG_DEFINES_VH
`define CMP_TRIG_DEFINES_VH
// register byte offsets on the apb bus
`define OFS_CTRL 12'h000
`define OFS_GATE 12'h004
`define OFS_IEN 12'h008
`define OFS_STAT 12'h00c
`define OFS_MASK 12'h010
// control register fields
`define CTRL_EN 7
`define CTRL_NSEL 6
`define CTRL_PSRC_HI 5
`define CTRL_PSRC_LO 4
`define CTRL_OEN 3
`define CTRL_LEVEL 2
`define CTRL_EDGE_HI 1
`define CTRL_EDGE_LO 0
// gating register fields
`define GATE_SYNC 2
`define GATE_MODE_HI 1
`define GATE_MODE_LO 0
// interrupt enable register fields
`define IEN_GLOBAL 1
`define IEN_CMP 0
// status and mask fields
`define ST_TRIG 0
`define ST_ERR 1
`define ST_W 2
// reset values
`define CTRL_RST 8'h00
`define GATE_RST 3'h0
`define IEN_RST 2'h0
`define MASK_RST 2'h0
// edge select codes
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
// gating mode codes
`define GMODE_OFF 2'h0
`define GMODE_FLAG 2'h1
`define GMODE_RISE_RUN 2'h2
`define GMODE_FALL_RUN 2'h3
// positive source codes
`define PSRC_2V 2'h0
`define PSRC_3V 2'h1
`define PSRC_4V 2'h2
`define PSRC_PIN 2'h3
`endif

//--- verilog/cmp_trig_ctrl.v
// comparator trigger control: pin routing, edge trigger, interrupt, wake-up, pwm gating
//
// Functional notes
// - result high when positive input above negative input, low when below
// - positive source codes 00/01/10 pick 2V/3V/4V reference, 11 picks external pin
// - with comparator disabled, comparator off and all its pins stay GPIO
// - enabled: select 0 uses negative pin a, select 1 uses pin b; other stays GPIO
// - output pin enable drives result onto output pin, isolating its GPIO
// - output-level flag reads the present comparator result
// - chosen edge of the result sets the trigger flag in hardware
// - edge select 01 rising, 10 falling, 11 both, 00 reserved with no trigger
// - trigger flag stays set until software clears it; hardware never clears it
// - interrupt request while flag set with comparator and global enables set
// - flag with comparator interrupt enabled wakes from IDLE, never from STOP
// - gating mode 00 leaves pwm alone; 01 stops pwm while trigger flag set
// - gating mode 10: rising edge lets pwm run, falling edge stops it
// - gating mode 11: falling edge lets pwm run, rising edge stops it
// - gating acts only while the pwm synchronous trigger enable is set
//
// register map, one word each, every field in the low byte
// 0x000 control: b7 enable, b6 negative pin select, b5:4 positive source,
//   b3 output pin enable, b2 live level (read only), b1:0 edge select
// 0x004 gating: b2 pwm sync trigger enable, b1:0 gating mode
// 0x008 interrupt enable: b1 global, b0 comparator
// 0x00c status, write one to clear: b0 trigger flag, b1 bus error
// 0x010 mask: same layout as status, feeds the irq output
// bus: one wait state, pready pulses for one cycle in the access phase
// unmapped addresses answer with pslverr and set the bus error bit
// writes with byte lane 0 off are ignored; upper bits read as zero
// trigger flag sets whatever the interrupt enables say; set beats a clear
// gating modes 10 and 11 keep a run latch that starts at run after reset
// with the comparator enabled, a mode change to 00 or 01 returns that latch to run
// idle_mode and stop_mode come from the cpu on this clock, so no synchroniser
// limitation: the live level lags the analogue result by two clocks
`timescale 1ns/100ps
`include "cmp_trig_defines.vh"
module cmp_trig_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cmp_result_async,
  input wire idle_mode,
  input wire stop_mode,
  output reg comparator_on,
  output reg [1:0] positive_source_select,
  output reg negative_input_pin_a_sel,
  output reg negative_input_pin_b_sel,
  output reg positive_input_pin_sel,
  output reg result_output_pin,
  output reg result_output_pin_oe,
  output reg cmp_irq_req,
  output reg wakeup_req,
  output reg pwm_stop,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] ctrl_q;
  reg [2:0] gate_q;
  reg [1:0] ien_q;
  reg [`ST_W-1:0] stat_q;
  reg [`ST_W-1:0] mask_q;
  reg sync1_q;
  reg sync2_q;
  reg prev_q;
  reg gate_run_q;
  reg [`ST_W-1:0] stat_d;
  reg [31:0] rdata_d;
  reg trig_ev;
  reg addr_ok;

  wire cmp_en = ctrl_q[`CTRL_EN];
  wire [1:0] edge_sel = ctrl_q[`CTRL_EDGE_HI:`CTRL_EDGE_LO];
  wire [1:0] gmode = gate_q[`GATE_MODE_HI:`GATE_MODE_LO];
  wire access = psel && penable && pready;
  wire wr = access && pwrite;
  wire rise = sync2_q && !prev_q;
  wire fall = !sync2_q && prev_q;
  // write to byte lane 0 only matters; every field lives in the low byte
  wire lane0 = pstrb[0];

  // map an address to its valid flag
  function known;
    input [11:0] a;
    begin
      known = (a == `OFS_CTRL) || (a == `OFS_GATE) || (a == `OFS_IEN) ||
              (a == `OFS_STAT) || (a == `OFS_MASK);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser of the analogue result; first stage read only by the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= cmp_result_async;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge history; resets to the off level so no false edge follows reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sync2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge decode; disabled comparator never triggers
  always @* begin
    trig_ev = 1'b0;
    if (cmp_en) begin
      case (edge_sel)
        `EDGE_RISE: trig_ev = rise;
        `EDGE_FALL: trig_ev = fall;
        `EDGE_BOTH: trig_ev = rise || fall;
        default: trig_ev = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status: set wins over a write-one clear in the same cycle
  always @* begin
    stat_d = stat_q;
    if (wr && lane0 && paddr == `OFS_STAT) begin
      stat_d = stat_q & ~pwdata[`ST_W-1:0];
    end
    if (trig_ev) begin
      stat_d[`ST_TRIG] = 1'b1;
    end
    if (access && !addr_ok) begin
      stat_d[`ST_ERR] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; level flag reads the synchronised live result
  always @* begin
    addr_ok = known(paddr);
    rdata_d = 32'h00000000;
    case (paddr)
      `OFS_CTRL: rdata_d = {24'h000000, ctrl_q[7:3], sync2_q, ctrl_q[1:0]};
      `OFS_GATE: rdata_d = {29'h00000000, gate_q};
      `OFS_IEN: rdata_d = {30'h00000000, ien_q};
      `OFS_STAT: rdata_d = {30'h00000000, stat_q};
      `OFS_MASK: rdata_d = {30'h00000000, mask_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, pready pulses in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data stands only in the answer cycle; zero otherwise keeps the bus quiet
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready && !pwrite) begin
      prdata <= rdata_d;
    end else begin
      prdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status register; only reset or a software write clears it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= {`ST_W{1'b0}};
    end else begin
      stat_q <= stat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software writable registers; level bit is read-only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RST;
      gate_q <= `GATE_RST;
      ien_q <= `IEN_RST;
      mask_q <= `MASK_RST;
    end else if (wr && lane0) begin
      case (paddr)
        `OFS_CTRL: ctrl_q <= {pwdata[7:3], 1'b0, pwdata[1:0]};
        `OFS_GATE: gate_q <= pwdata[2:0];
        `OFS_IEN: ien_q <= pwdata[1:0];
        `OFS_MASK: mask_q <= pwdata[`ST_W-1:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm run latch for the edge-driven gating modes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_run_q <= 1'b1;
    end else if (cmp_en) begin
      if (gmode == `GMODE_RISE_RUN) begin
        if (rise) gate_run_q <= 1'b1;
        else if (fall) gate_run_q <= 1'b0;
      end else if (gmode == `GMODE_FALL_RUN) begin
        if (fall) gate_run_q <= 1'b1;
        else if (rise) gate_run_q <= 1'b0;
      end else begin
        gate_run_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin routing toward the analogue stage and the shared pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_on <= 1'b0;
      positive_source_select <= `PSRC_2V;
      negative_input_pin_a_sel <= 1'b0;
      negative_input_pin_b_sel <= 1'b0;
      positive_input_pin_sel <= 1'b0;
    end else begin
      comparator_on <= cmp_en;
      positive_source_select <= ctrl_q[`CTRL_PSRC_HI:`CTRL_PSRC_LO];
      positive_input_pin_sel <= cmp_en &&
        (ctrl_q[`CTRL_PSRC_HI:`CTRL_PSRC_LO] == `PSRC_PIN);
      negative_input_pin_a_sel <= cmp_en && !ctrl_q[`CTRL_NSEL];
      negative_input_pin_b_sel <= cmp_en && ctrl_q[`CTRL_NSEL];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result output pin; pin is gpio whenever output enable is low, even if disabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_output_pin <= 1'b0;
      result_output_pin_oe <= 1'b0;
    end else begin
      result_output_pin_oe <= cmp_en && ctrl_q[`CTRL_OEN];
      result_output_pin <= cmp_en && ctrl_q[`CTRL_OEN] && sync2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt request, masked irq and idle wake-up
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_irq_req <= 1'b0;
      wakeup_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      cmp_irq_req <= stat_q[`ST_TRIG] && ien_q[`IEN_CMP] && ien_q[`IEN_GLOBAL];
      // stop mode has no clock path back here, so it never wakes
      wakeup_req <= idle_mode && !stop_mode && stat_q[`ST_TRIG] &&
        ien_q[`IEN_CMP];
      irq <= |(stat_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm stop; gating acts only with the sync trigger enable and comparator on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_stop <= 1'b0;
    end else if (!gate_q[`GATE_SYNC] || !cmp_en) begin
      pwm_stop <= 1'b0;
    end else begin
      case (gmode)
        `GMODE_FLAG: pwm_stop <= stat_q[`ST_TRIG];
        `GMODE_RISE_RUN: pwm_stop <= !gate_run_q;
        `GMODE_FALL_RUN: pwm_stop <= !gate_run_q;
        default: pwm_stop <= 1'b0;
      endcase
    end
  end

endmodule // cmp_trig_ctrl

//--- dv/cmp_stage_model.sv
// behavioural analogue comparator stage feeding the async result
`timescale 1ns/100ps
module cmp_stage_model (
  input wire comparator_on,
  input wire [1:0] positive_source_select,
  input wire logic [15:0] pin_mv,
  input wire logic [15:0] neg_mv,
  output logic cmp_result_async
);
  logic [15:0] pos_mv;
  // reference steps in millivolts, or the pin; off stage rests low
  always_comb begin
    pos_mv = 16'h07d0 + {14'h0, positive_source_select} * 16'h03e8;
    if (positive_source_select == 2'h3) pos_mv = pin_mv;
    cmp_result_async = comparator_on && (pos_mv > neg_mv);
  end
endmodule // cmp_stage_model

//--- dv/cmp_trig_ctrl_properties.sv
// checker of the comparator trigger control top ports
`timescale 1ns/100ps
module cmp_trig_ctrl_properties (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire pslverr,
  input wire idle_mode,
  input wire stop_mode,
  input wire comparator_on,
  input wire [1:0] positive_source_select,
  input wire negative_input_pin_a_sel,
  input wire negative_input_pin_b_sel,
  input wire positive_input_pin_sel,
  input wire wakeup_req,
  input wire irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase still waiting for its answer
  sequence s_access;
    psel && penable && !pready;
  endsequence
  AST_READY_WAIT: assert property (s_access |=> pready) else $error("ready late");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("lone error");
  AST_PINS_OFF: assert property (!comparator_on |-> !(negative_input_pin_a_sel ||
    negative_input_pin_b_sel || positive_input_pin_sel)) else $error("pin taken while off");
  AST_NEG_ONE: assert property (comparator_on |->
    negative_input_pin_a_sel != negative_input_pin_b_sel) else $error("negative pin choice");
  AST_POS_PIN: assert property (comparator_on |->
    positive_input_pin_sel == (positive_source_select == 2'h3)) else $error("positive pin");
  AST_WAKE_IDLE: assert property (wakeup_req |->
    $past(idle_mode) && !$past(stop_mode)) else $error("wake outside idle");
  // only a software write may drop the interrupt
  AST_IRQ_HELD: assert property ($fell(irq) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2)) else $error("irq dropped");
endmodule // cmp_trig_ctrl_properties
bind cmp_trig_ctrl cmp_trig_ctrl_properties u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .pready, .pslverr, .idle_mode, .stop_mode, .comparator_on, .positive_source_select,
  .negative_input_pin_a_sel, .negative_input_pin_b_sel, .positive_input_pin_sel,
  .wakeup_req, .irq);

//--- dv/comparator_trigger_control_tb_top.sv
// self-checking bench of the comparator trigger control
`timescale 1ns/100ps
`include "cmp_trig_defines.vh"
module comparator_trigger_control_tb_top;
  logic pclk, presetn, psel, penable, pwrite, idle_mode, stop_mode, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [15:0] pin_mv, neg_mv;
  wire [31:0] prdata;
  wire [1:0] positive_source_select;
  wire pready, pslverr, cmp_result_async, comparator_on, negative_input_pin_a_sel;
  wire negative_input_pin_b_sel, positive_input_pin_sel, result_output_pin;
  wire result_output_pin_oe, cmp_irq_req, wakeup_req, pwm_stop, irq;
  int fail_count, check_count;
  typedef struct packed {
    logic [7:0] c;
    logic [15:0] n0;
    logic [15:0] n1;
    logic lvl;
    logic flg;
    logic [5:0] pin;
  } row_t;
  // control byte, negative input before and after, level and flag expected,
  // then pins expected as {on, negative a, negative b, positive pin, source}
  row_t rows [8] = '{'{8'h81, 16'h1388, 16'h03e8, 1'b1, 1'b1, 6'h30},
    '{8'h82, 16'h1388, 16'h03e8, 1'b1, 1'b0, 6'h30},
    '{8'h91, 16'h0dac, 16'h09c4, 1'b1, 1'b1, 6'h31},
    '{8'ha2, 16'h0dac, 16'h1194, 1'b0, 1'b1, 6'h32},
    '{8'hb3, 16'h0bb8, 16'h07d0, 1'b1, 1'b1, 6'h37},
    '{8'hb0, 16'h0bb8, 16'h07d0, 1'b1, 1'b0, 6'h37},
    '{8'h32, 16'h03e8, 16'h0bb8, 1'b0, 1'b0, 6'h03},
    '{8'hc2, 16'h03e8, 16'h0bb8, 1'b0, 1'b1, 6'h28}};
  logic [11:0] offs [4] = '{`OFS_CTRL, `OFS_GATE, `OFS_IEN, `OFS_MASK};
  cmp_trig_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .cmp_result_async, .idle_mode, .stop_mode,
    .comparator_on, .positive_source_select, .negative_input_pin_a_sel,
    .negative_input_pin_b_sel, .positive_input_pin_sel, .result_output_pin,
    .result_output_pin_oe, .cmp_irq_req, .wakeup_req, .pwm_stop, .irq);
  cmp_stage_model model (.comparator_on, .positive_source_select, .pin_mv, .neg_mv,
    .cmp_result_async);
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  // one apb transfer; bounded wait for ready, data taken in that cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request holds until the edge that samples pready high; answer taken there
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      final_report;
    end
  endtask
  // move the negative input and let the synchroniser settle
  task automatic drive_neg(input logic [15:0] v);
    @(posedge pclk);
    neg_mv <= v;
    repeat (8) @(negedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, idle_mode, stop_mode} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pin_mv = 16'h09c4;
    neg_mv = 16'h1388;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      chk(rd, 32'h0);
    end
    foreach (rows[i]) begin
      apb(1'b1, `OFS_CTRL, {24'h0, rows[i].c});
      drive_neg(rows[i].n0);
      apb(1'b1, `OFS_STAT, 32'h1);
      drive_neg(rows[i].n1);
      chk({comparator_on, negative_input_pin_a_sel, negative_input_pin_b_sel,
        positive_input_pin_sel, positive_source_select}, rows[i].pin);
      apb(1'b0, `OFS_CTRL, 32'h0);
      chk(rd[`CTRL_LEVEL], rows[i].lvl);
      apb(1'b0, `OFS_STAT, 32'h0);
      chk(rd[`ST_TRIG], rows[i].flg);
    end
    apb(1'b1, `OFS_CTRL, 32'h89);
    idle_mode <= 1'b1;
    drive_neg(16'h1388);
    apb(1'b1, `OFS_STAT, 32'h1);
    apb(1'b1, `OFS_IEN, 32'h3);
    apb(1'b1, `OFS_MASK, 32'h1);
    drive_neg(16'h03e8);
    chk(cmp_irq_req, 1'b1);
    chk(irq, 1'b1);
    chk(wakeup_req, 1'b1);
    chk({result_output_pin_oe, result_output_pin}, 2'h3);
    @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (3) @(negedge pclk);
    chk(wakeup_req, 1'b0);
    apb(1'b1, `OFS_MASK, 32'h0);
    repeat (3) @(negedge pclk);
    chk({irq, cmp_irq_req}, 2'h1);
    apb(1'b1, `OFS_GATE, 32'h5);
    repeat (3) @(negedge pclk);
    chk(pwm_stop, 1'b1);
    apb(1'b1, `OFS_GATE, 32'h1);
    repeat (3) @(negedge pclk);
    chk(pwm_stop, 1'b0);
    apb(1'b1, `OFS_STAT, 32'h1);
    apb(1'b1, `OFS_GATE, 32'h6);
    repeat (3) @(negedge pclk);
    chk({cmp_irq_req, pwm_stop}, 2'h0);
    drive_neg(16'h1388);
    chk(pwm_stop, 1'b1);
    drive_neg(16'h03e8);
    chk(pwm_stop, 1'b0);
    apb(1'b1, `OFS_GATE, 32'h7);
    drive_neg(16'h1388);
    chk(pwm_stop, 1'b0);
    drive_neg(16'h03e8);
    chk(pwm_stop, 1'b1);
    apb(1'b0, 12'h020, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b0, `OFS_STAT, 32'h0);
    chk(rd[`ST_ERR], 1'b1);
    // reset in mid-run: outputs drop at once, registers come back at reset values
    presetn <= 1'b0;
    @(negedge pclk);
    chk({comparator_on, pwm_stop, cmp_irq_req, result_output_pin_oe}, 4'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_GATE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `OFS_STAT, 32'h0);
    chk(rd, 32'h0);
    final_report;
  end
endmodule // comparator_trigger_control_tb_top
